// [pkg/lcfg_pkg.sv]
/*
 package for the channel test and loop configuration bank:
 register offsets, field positions, reset values and decoded modes.
 assumes a byte-wide register port with one cycle read latency.
*/
package lcfg_pkg;

   // =======================================================
   // register map
   localparam logic [7:0] LCFG_ADDR_JITTER  = 8'h01; // jitter_fifo_config
   localparam logic [7:0] LCFG_ADDR_TESTPWR = 8'h02; // test_power_loop_config
   localparam logic [7:0] LCFG_RESET_VALUE  = 8'h00; // both registers

   // =======================================================
   // field positions
   localparam int LCFG_BIT_FIFO_DEPTH = 0; // jitter_fifo_config
   localparam int LCFG_BIT_JITTER_BW  = 1;
   localparam int LCFG_BIT_LOOP_LO    = 0; // test_power_loop_config
   localparam int LCFG_BIT_LOOP_HI    = 2;
   localparam int LCFG_BIT_TX_POWER   = 3;
   localparam int LCFG_BIT_PAT_LO     = 4;
   localparam int LCFG_BIT_PAT_HI     = 6;
   localparam int LCFG_BIT_INVERT     = 7;

   // =======================================================
   // fifo depths in bits
   localparam logic [6:0] LCFG_DEPTH_SHORT = 7'h20; // 32 bits
   localparam logic [6:0] LCFG_DEPTH_LONG  = 7'h40; // 64 bits

   // jitter bandwidth, encoded as the attenuator selects it
   typedef enum logic [1:0] {
      LCFG_BW_10HZ  = 2'h0,
      LCFG_BW_1P5HZ = 2'h1,
      LCFG_BW_3HZ   = 2'h3
   } lcfg_bw_type;

   // transmit test pattern
   typedef enum logic [1:0] {
      LCFG_PAT_NONE     = 2'h0,
      LCFG_PAT_QUASI    = 2'h1,
      LCFG_PAT_ALL_ONES = 2'h3,
      LCFG_PAT_RESERVED = 2'h2
   } lcfg_pat_type;

   // loopback mode
   typedef enum logic [2:0] {
      LCFG_LOOP_NONE    = 3'h0,
      LCFG_LOOP_DUAL    = 3'h1,
      LCFG_LOOP_ANALOG  = 3'h3,
      LCFG_LOOP_REMOTE  = 3'h2,
      LCFG_LOOP_DIGITAL = 3'h6
   } lcfg_loop_type;

endpackage

// [src/lcfg_bank.sv]
/*
 per-channel configuration bank: jitter attenuator bandwidth and
 depth, transmit test pattern and inversion, transmit power and
 loopback select, reached over a byte register port.
 assumes a single 20 MHz clock and a master that never overlaps
 strobes; the line side reads the registered control outputs.
*/
// Notes on behaviour
// - e1 bandwidth from bit, t1 fixed 3hz
// - one bandwidth drives receive and transmit
// - depth bit picks 32 or 64 bits
// - fifo latency is half the depth
// - one depth drives receive and transmit
// - invert bit flips selected random pattern
// - default: quasi-random inverted, other patterns plain
// - pattern field: none, quasi, ones, reserved
// - transmitter off at reset, bit controls it
// - gate pin low forces transmitter off
// - loop field: none, dual, analog, remote, digital
`timescale 1ns/1ps

module lcfg_bank (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // register port
   input  wire logic [7:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output      logic [7:0]             reg_rdata,
   // channel mode and pin
   input  wire logic                   e1_mode,
   input  wire logic                   tx_power_gate_pin,
   // jitter attenuator controls
   output      lcfg_pkg::lcfg_bw_type   rx_bw_sel,
   output      lcfg_pkg::lcfg_bw_type   tx_bw_sel,
   output      logic [6:0]              rx_fifo_depth,
   output      logic [6:0]              tx_fifo_depth,
   output      logic [5:0]              fifo_latency,
   // transmit test and power
   output      lcfg_pkg::lcfg_pat_type  pattern_sel,
   output      logic                    pattern_inverted,
   output      logic                    tx_powered,
   // loopback
   output      lcfg_pkg::lcfg_loop_type loop_sel
);
   import lcfg_pkg::*;

   // =======================================================
   // stored fields
   logic       jitter_bw_select_q;  // bandwidth bit
   logic       fifo_depth_select_q; // depth bit
   logic       pattern_invert_q;    // inversion bit
   logic [2:0] tx_pattern_select_q; // pattern field, reserved kept
   logic       tx_power_on_bit_q;   // transmitter power bit
   logic [2:0] loop_select_q;       // loopback field
   logic       tx_powered_q;        // registered power control

   lcfg_bw_type   bw_w;
   logic [6:0]    depth_w;
   logic [5:0]    lat_w;
   lcfg_pat_type  pat_w;
   logic          inv_w;
   lcfg_loop_type loop_w;

   wire wr_jit = reg_wr && (reg_addr == LCFG_ADDR_JITTER);
   wire wr_tpl = reg_wr && (reg_addr == LCFG_ADDR_TESTPWR);

   // =======================================================
   // register writes
   always_ff @(posedge clk) begin
      // every field clears on reset
      if (srst) begin
         jitter_bw_select_q  <= LCFG_RESET_VALUE[LCFG_BIT_JITTER_BW];
         fifo_depth_select_q <= LCFG_RESET_VALUE[LCFG_BIT_FIFO_DEPTH];
      end else if (wr_jit) begin
         jitter_bw_select_q  <= reg_wdata[LCFG_BIT_JITTER_BW];
         fifo_depth_select_q <= reg_wdata[LCFG_BIT_FIFO_DEPTH];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pattern_invert_q    <= 1'b0;
         tx_pattern_select_q <= 3'h0;
         tx_power_on_bit_q   <= 1'b0;
         loop_select_q       <= 3'h0;
      end else if (wr_tpl) begin
         // reserved pattern codes stored as written
         pattern_invert_q    <= reg_wdata[LCFG_BIT_INVERT];
         tx_pattern_select_q <= reg_wdata[LCFG_BIT_PAT_HI:LCFG_BIT_PAT_LO];
         tx_power_on_bit_q   <= reg_wdata[LCFG_BIT_TX_POWER];
         loop_select_q       <= reg_wdata[LCFG_BIT_LOOP_HI:LCFG_BIT_LOOP_LO];
      end
   end

   // =======================================================
   // register reads, data in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            LCFG_ADDR_JITTER:
               reg_rdata <= {6'h00, jitter_bw_select_q,
                             fifo_depth_select_q};
            LCFG_ADDR_TESTPWR:
               reg_rdata <= {pattern_invert_q, tx_pattern_select_q,
                             tx_power_on_bit_q, loop_select_q};
            // unmapped addresses read as zero
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // =======================================================
   // transmitter power: pin gates every channel's bit
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_powered_q <= 1'b0;
      end else begin
         tx_powered_q <= tx_power_gate_pin & tx_power_on_bit_q;
      end
   end
   assign tx_powered = tx_powered_q;

   // =======================================================
   // field decode
   lcfg_decode u_decode (
      .e1_mode           (e1_mode),
      .jitter_bw_select  (jitter_bw_select_q),
      .fifo_depth_select (fifo_depth_select_q),
      .tx_pattern_select (tx_pattern_select_q),
      .loop_select       (loop_select_q),
      .pattern_invert    (pattern_invert_q),
      .bw_sel            (bw_w),
      .depth_bits        (depth_w),
      .latency_bits      (lat_w),
      .pat_sel           (pat_w),
      .pat_inverted      (inv_w),
      .loop_sel          (loop_w)
   );

   // controls are registered so the line side sees clean levels
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_bw_sel        <= LCFG_BW_3HZ;
         tx_bw_sel        <= LCFG_BW_3HZ;
         rx_fifo_depth    <= LCFG_DEPTH_SHORT;
         tx_fifo_depth    <= LCFG_DEPTH_SHORT;
         fifo_latency     <= LCFG_DEPTH_SHORT[6:1];
         pattern_sel      <= LCFG_PAT_NONE;
         pattern_inverted <= 1'b0;
         loop_sel         <= LCFG_LOOP_NONE;
      end else begin
         rx_bw_sel        <= bw_w;
         tx_bw_sel        <= bw_w;
         rx_fifo_depth    <= depth_w;
         tx_fifo_depth    <= depth_w;
         fifo_latency     <= lat_w;
         pattern_sel      <= pat_w;
         pattern_inverted <= inv_w;
         loop_sel         <= loop_w;
      end
   end

   // =======================================================
   // checks
   property p_bw_t1;
      @(posedge clk) disable iff (srst)
      !e1_mode |=> rx_bw_sel == LCFG_BW_3HZ;
   endproperty
   a_bw_t1: assert property (p_bw_t1)
      else $error("t1 bandwidth not fixed");

   property p_bw_e1;
      @(posedge clk) disable iff (srst)
      e1_mode && jitter_bw_select_q |=> rx_bw_sel == LCFG_BW_1P5HZ;
   endproperty
   a_bw_e1: assert property (p_bw_e1)
      else $error("e1 narrow bandwidth not selected");

   property p_bw_same;
      @(posedge clk) disable iff (srst) rx_bw_sel == tx_bw_sel;
   endproperty
   a_bw_same: assert property (p_bw_same)
      else $error("bandwidths differ");

   property p_depth;
      @(posedge clk) disable iff (srst)
      fifo_depth_select_q |=> rx_fifo_depth == 7'h40;
   endproperty
   a_depth: assert property (p_depth)
      else $error("deep fifo not selected");

   // checked against the fixed half of the short depth, not the depth
   // output, so a broken divide in the decode is still caught
   property p_latency;
      @(posedge clk) disable iff (srst)
      !fifo_depth_select_q |=> fifo_latency == 6'h10;
   endproperty
   a_latency: assert property (p_latency)
      else $error("latency not half depth");

   property p_depth_same;
      @(posedge clk) disable iff (srst) rx_fifo_depth == tx_fifo_depth;
   endproperty
   a_depth_same: assert property (p_depth_same)
      else $error("fifo depths differ");

   property p_invert;
      @(posedge clk) disable iff (srst)
      tx_pattern_select_q == 3'h4 |=> pattern_inverted
         == !$past(pattern_invert_q);
   endproperty
   a_invert: assert property (p_invert)
      else $error("quasi-random inversion wrong");

   property p_pat;
      @(posedge clk) disable iff (srst)
      !tx_pattern_select_q[2] |=> pattern_sel == LCFG_PAT_NONE;
   endproperty
   a_pat: assert property (p_pat)
      else $error("pattern sent with top bit clear");

   property p_gate;
      @(posedge clk) disable iff (srst)
      !tx_power_gate_pin |=> !tx_powered;
   endproperty
   a_gate: assert property (p_gate)
      else $error("transmitter on with pin low");

   property p_loop;
      @(posedge clk) disable iff (srst)
      loop_select_q == 3'h7 |=> loop_sel == LCFG_LOOP_DIGITAL;
   endproperty
   a_loop: assert property (p_loop)
      else $error("digital loopback not decoded");

   property p_readback;
      @(posedge clk) disable iff (srst)
      reg_wr && reg_addr == LCFG_ADDR_TESTPWR ##1
         reg_rd && reg_addr == LCFG_ADDR_TESTPWR && !reg_wr
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_readback: assert property (p_readback)
      else $error("read does not return last write");

   c_power: cover property (@(posedge clk) tx_powered);
   c_quasi: cover property (@(posedge clk) pattern_sel == LCFG_PAT_QUASI);
   c_remote: cover property (@(posedge clk) loop_sel == LCFG_LOOP_REMOTE);
   c_deep: cover property (@(posedge clk) fifo_latency == 6'h20);

endmodule // lcfg_bank

// [src/lcfg_decode.sv]
/*
 combinational decode of the stored fields into the controls that
 the jitter attenuator, pattern generator and loopback muxes use.
 assumes the fields come straight from the register flip-flops.
*/
`timescale 1ns/1ps

module lcfg_decode (
   // line mode and stored fields
   input  wire logic                   e1_mode,
   input  wire logic                   jitter_bw_select,
   input  wire logic                   fifo_depth_select,
   input  wire logic [2:0]             tx_pattern_select,
   input  wire logic [2:0]             loop_select,
   input  wire logic                   pattern_invert,
   // decoded controls
   output      lcfg_pkg::lcfg_bw_type   bw_sel,
   output      logic [6:0]              depth_bits,
   output      logic [5:0]              latency_bits,
   output      lcfg_pkg::lcfg_pat_type  pat_sel,
   output      logic                    pat_inverted,
   output      lcfg_pkg::lcfg_loop_type loop_sel
);
   import lcfg_pkg::*;

   // =======================================================
   // jitter attenuator
   always_comb begin
      // t1 ignores the bit and stays at the middle bandwidth
      if (!e1_mode) begin
         bw_sel = LCFG_BW_3HZ;
      end else if (jitter_bw_select) begin
         bw_sel = LCFG_BW_1P5HZ;
      end else begin
         bw_sel = LCFG_BW_10HZ;
      end
   end

   // depth and half-depth latency
   assign depth_bits   = fifo_depth_select ? LCFG_DEPTH_LONG
                                           : LCFG_DEPTH_SHORT;
   assign latency_bits = depth_bits[6:1];

   // =======================================================
   // pattern and loopback decode
   always_comb begin
      case (tx_pattern_select)
         3'h4:    pat_sel = LCFG_PAT_QUASI;
         3'h5:    pat_sel = LCFG_PAT_ALL_ONES;
         3'h6,
         3'h7:    pat_sel = LCFG_PAT_RESERVED;
         default: pat_sel = LCFG_PAT_NONE;
      endcase
   end

   // quasi-random goes out inverted unless the bit is set
   assign pat_inverted = (pat_sel == LCFG_PAT_QUASI) ? ~pattern_invert
                                                     : 1'b0;

   always_comb begin
      case (loop_select)
         3'h4:    loop_sel = LCFG_LOOP_DUAL;
         3'h5:    loop_sel = LCFG_LOOP_ANALOG;
         3'h6:    loop_sel = LCFG_LOOP_REMOTE;
         3'h7:    loop_sel = LCFG_LOOP_DIGITAL;
         default: loop_sel = LCFG_LOOP_NONE;
      endcase
   end

endmodule // lcfg_decode

// [tb/lcfg_bank_tb.sv]
/*
 self-checking bench for the channel test and loop configuration bank:
 register tasks, reset values, field decode, power gating, unmapped
 addresses and a second reset in mid-run.
 assumes the bank answers a read in the cycle after the strobe and
 moves its registered controls one edge after a stored field changes.
*/
`timescale 1ns/1ps

// =======================================================
// shared compare: counts every check, reports each mismatch at once
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         err_total++; \
         $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module lcfg_bank_tb;
   import lcfg_pkg::*;

   // =======================================================
   // clock, reset and design inputs
   logic          clk = 1'b0;        // 20 MHz bench clock
   logic          srst;              // synchronous reset, high
   logic [7:0]    reg_addr;          // register address
   logic [7:0]    reg_wdata;         // write data
   logic          reg_wr;            // write strobe
   logic          reg_rd;            // read strobe
   logic          e1_mode;           // 1 = e1, 0 = t1
   logic          tx_power_gate_pin; // external transmit enable
   // design outputs
   logic [7:0]    reg_rdata;         // read data, one cycle only
   lcfg_bw_type   rx_bw_sel;         // receive bandwidth
   lcfg_bw_type   tx_bw_sel;         // transmit bandwidth
   logic [6:0]    rx_fifo_depth;     // receive fifo depth
   logic [6:0]    tx_fifo_depth;     // transmit fifo depth
   logic [5:0]    fifo_latency;      // half the depth
   lcfg_pat_type  pattern_sel;       // transmit test pattern
   logic          pattern_inverted;  // pattern inversion
   logic          tx_powered;        // transmitter on
   lcfg_loop_type loop_sel;          // loopback mode
   // bookkeeping
   int            err_total   = 0;   // mismatches seen
   int            comparisons = 0;   // compares made

   // =======================================================
   // clock: half period of 25 ns
   always #25 clk = ~clk;

   lcfg_bank dut (
      .clk               (clk),
      .srst              (srst),
      .reg_addr          (reg_addr),
      .reg_wdata         (reg_wdata),
      .reg_wr            (reg_wr),
      .reg_rd            (reg_rd),
      .reg_rdata         (reg_rdata),
      .e1_mode           (e1_mode),
      .tx_power_gate_pin (tx_power_gate_pin),
      .rx_bw_sel         (rx_bw_sel),
      .tx_bw_sel         (tx_bw_sel),
      .rx_fifo_depth     (rx_fifo_depth),
      .tx_fifo_depth     (tx_fifo_depth),
      .fifo_latency      (fifo_latency),
      .pattern_sel       (pattern_sel),
      .pattern_inverted  (pattern_inverted),
      .tx_powered        (tx_powered),
      .loop_sel          (loop_sel)
   );

   // =======================================================
   // register port tasks
   // one-cycle write strobe launched right after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // read: data is taken in the one cycle after the strobe edge
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      `CHK(reg_rdata, exp)
   endtask

   // hold reset for four edges, then release
   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      #1;
   endtask

   // =======================================================
   // expected controls, worked out from the field values
   task automatic chk_jit(input logic [1:0] v);
      lcfg_bw_type bw;
      logic [6:0]  dep;
      // t1 ignores the bandwidth bit entirely
      bw  = !e1_mode ? LCFG_BW_3HZ : (v[1] ? LCFG_BW_1P5HZ : LCFG_BW_10HZ);
      dep = v[0] ? LCFG_DEPTH_LONG : LCFG_DEPTH_SHORT;
      `CHK(rx_bw_sel, bw)
      `CHK(tx_bw_sel, bw)
      `CHK(rx_fifo_depth, dep)
      `CHK(tx_fifo_depth, dep)
      `CHK(fifo_latency, dep[6:1])
   endtask

   task automatic chk_tpl(input logic [7:0] d);
      lcfg_pat_type  pat;
      lcfg_loop_type lp;
      pat = !d[6] ? LCFG_PAT_NONE : d[5] ? LCFG_PAT_RESERVED :
            d[4] ? LCFG_PAT_ALL_ONES : LCFG_PAT_QUASI;
      case (d[1:0])
         2'h0: lp = LCFG_LOOP_DUAL;
         2'h1: lp = LCFG_LOOP_ANALOG;
         2'h2: lp = LCFG_LOOP_REMOTE;
         default: lp = LCFG_LOOP_DIGITAL;
      endcase
      if (!d[2]) begin
         lp = LCFG_LOOP_NONE;
      end
      `CHK(pattern_sel, pat)
      `CHK(pattern_inverted, (pat == LCFG_PAT_QUASI) & ~d[7])
      `CHK(tx_powered, tx_power_gate_pin & d[3])
      `CHK(loop_sel, lp)
   endtask

   // controls and registers as a hardware reset leaves them
   task automatic chk_reset();
      `CHK(rx_bw_sel, LCFG_BW_3HZ)
      `CHK(rx_fifo_depth, LCFG_DEPTH_SHORT)
      `CHK(fifo_latency, 6'h10)
      `CHK(pattern_sel, LCFG_PAT_NONE)
      `CHK(pattern_inverted, 1'b0)
      `CHK(tx_powered, 1'b0)
      `CHK(loop_sel, LCFG_LOOP_NONE)
      rd_chk(LCFG_ADDR_JITTER, LCFG_RESET_VALUE);
      rd_chk(LCFG_ADDR_TESTPWR, LCFG_RESET_VALUE);
   endtask

   // =======================================================
   // verdict and end of run, shared by the sequence and the watchdog
   task automatic stop_test();
      $display("totals: %0d compares, %0d mismatches", comparisons,
               err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end

   // =======================================================
   // main sequence
   initial begin
      logic [7:0] d;
      srst              = 1'b1;
      reg_addr          = 8'h00;
      reg_wdata         = 8'h00;
      reg_wr            = 1'b0;
      reg_rd            = 1'b0;
      e1_mode           = 1'b0;
      tx_power_gate_pin = 1'b1;
      d                 = 8'h00;
      do_reset();
      chk_reset();
      // every bandwidth and depth value in both line modes;
      // upper bits are written as ones and must read back zero
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         e1_mode <= m[0];
         for (int v = 0; v < 4; v++) begin
            wr(LCFG_ADDR_JITTER, {6'h3F, v[1:0]});
            rd_chk(LCFG_ADDR_JITTER, {6'h00, v[1:0]});
            chk_jit(v[1:0]);
         end
      end
      // every pattern and loop code, invert both ways, power toggling
      for (int k = 0; k < 16; k++) begin
         d = {k[3], k[2:0], k[0], k[2:0]};
         wr(LCFG_ADDR_TESTPWR, d);
         rd_chk(LCFG_ADDR_TESTPWR, d);
         chk_tpl(d);
      end
      // gate pin overrides the power bit, one edge of pin latency
      wr(LCFG_ADDR_TESTPWR, 8'h08);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         tx_power_gate_pin <= p[0];
         repeat (2) @(posedge clk);
         #1;
         `CHK(tx_powered, p[0])
      end
      // read data stands one cycle, then drops to zero
      rd_chk(LCFG_ADDR_TESTPWR, 8'h08);
      @(posedge clk);
      #1;
      `CHK(reg_rdata, 8'h00)
      // unmapped places neither store nor disturb the bank
      wr(8'h03, 8'hA5);
      rd_chk(8'h03, 8'h00);
      rd_chk(8'h00, 8'h00);
      rd_chk(LCFG_ADDR_TESTPWR, 8'h08);
      // strobes with no gap: a write, then two reads held high
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= LCFG_ADDR_TESTPWR;
      reg_wdata <= 8'h5C;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge clk);
      reg_addr  <= LCFG_ADDR_JITTER;
      #1;
      `CHK(reg_rdata, 8'h5C)
      @(posedge clk);
      reg_rd    <= 1'b0;
      #1;
      `CHK(reg_rdata, 8'h03)
      chk_tpl(8'h5C);
      // second reset in mid-run with fields set and e1 selected
      wr(LCFG_ADDR_JITTER, 8'h03);
      @(posedge clk);
      e1_mode <= 1'b1;
      do_reset();
      chk_reset();
      // fields cleared, so e1 now picks the wide bandwidth
      chk_jit(2'h0);
      stop_test();
   end

endmodule // lcfg_bank_tb
